// ### logic/uss_pkg.sv
// Package: register map, field positions and reset values of the serial shift control
`default_nettype none
package uss_pkg;
  // Register byte offsets
  localparam logic [11:0] USS_CTRL_OFF   = 12'h000;
  localparam logic [11:0] USS_STAT_OFF   = 12'h004;
  localparam logic [11:0] USS_PINPOS_OFF = 12'h008;
  localparam logic [11:0] USS_DATA_OFF   = 12'h00C;
  localparam logic [11:0] USS_PORT_OFF   = 12'h010;
  // Control field positions
  localparam int CTRL_TOGGLE_BIT = 0;
  localparam int CTRL_STROBE_BIT = 1;
  localparam int CTRL_CS_LSB     = 2;
  localparam int CTRL_WM_LSB     = 4;
  // Status field positions
  localparam int STAT_CNT_LSB    = 0;
  localparam int STAT_OVF_BIT    = 6;
  localparam int STAT_START_BIT  = 7;
  // Port register field positions
  localparam int PORT_SDA_OUT    = 0;
  localparam int PORT_DO_OUT     = 1;
  localparam int PORT_SCL_OUT    = 2;
  localparam int PORT_SDA_DIR    = 3;
  localparam int PORT_DO_DIR     = 4;
  localparam int PORT_SCL_DIR    = 5;
  // Reset values
  localparam logic [7:0] CTRL_RESET   = 8'h00;
  localparam logic [7:0] PINPOS_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET   = 8'h00;
  localparam logic [5:0] PORT_RESET   = 6'h00;
  localparam logic [3:0] CNT_RESET    = 4'h0;
  localparam logic [3:0] CNT_MAX      = 4'hF;
  // Wire modes
  typedef enum logic [1:0] {
    WM_OFF   = 2'b00,
    WM_THREE = 2'b01,
    WM_TWO   = 2'b10,
    WM_TWO_H = 2'b11
  } uss_wm_t;
  // Clock sources
  typedef enum logic [1:0] {
    CS_SOFT  = 2'b00,
    CS_TIMER = 2'b01,
    CS_EXTP  = 2'b10,
    CS_EXTN  = 2'b11
  } uss_cs_t;
endpackage
`default_nettype wire

// ### logic/uss_core.sv
// Serial shift control: wire modes, clock sources, strobes, pin routing, APB registers
//
// The APB slave port and the placing of the registers were decided locally.
`default_nettype none
module uss_core
  import uss_pkg::*;
#(
  parameter int DATA_W = 8
)(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // Timer compare match and start detector
  input  wire logic        timer_match,
  input  wire logic        start_detect,
  // Port B pins 0..2 (oe low = driving)
  input  wire logic [2:0]  pb_in,
  output logic [2:0]       pb_out,
  output logic [2:0]       pb_oe_n,
  output logic [2:0]       pb_pullup_off,
  // Port A pins 2,4,5 as [0]=PA4,[1]=PA2,[2]=PA5
  input  wire logic [2:0]  pa_in,
  output logic [2:0]       pa_out,
  output logic [2:0]       pa_oe_n,
  output logic [2:0]       pa_pullup_off
);

  logic [7:0]        ctrl_q;
  logic              pinpos_q;
  logic [DATA_W-1:0] data_q;
  logic [5:0]        port_q;
  logic [3:0]        cnt_q;
  logic              ovf_q;
  logic              start_q;
  logic              dout_q;
  logic [5:0]        pin_s1_q;
  logic [5:0]        pin_s2_q;
  logic              sclk_prev_q;
  logic              sdi_prev_q;
  logic              tm_s1_q;
  logic              tm_s2_q;
  logic              tm_prev_q;

  uss_wm_t wm;
  uss_cs_t cs;
  logic    strobe_sel;
  logic    wr, rd;
  logic    wr_ctrl, wr_stat, wr_data;
  logic    strobe_wr, toggle_wr;
  logic    sclk_in, sdi_in;
  logic    rise, fall;
  logic    tm_pulse;
  logic    shift_en, count_en;
  logic    two_wire;
  logic    scl_hold;
  logic    sda_low, scl_low;
  logic    dout_now;
  logic [2:0] ifc_out, ifc_oe_n;

  assign wm         = uss_wm_t'(ctrl_q[CTRL_WM_LSB +: 2]);
  assign cs         = uss_cs_t'(ctrl_q[CTRL_CS_LSB +: 2]);
  assign strobe_sel = ctrl_q[CTRL_STROBE_BIT];
  assign two_wire   = wm[1];

  // APB decode: zero-wait, unmapped reads zero with error
  assign pready    = 1'b1;
  assign wr        = psel && penable && pwrite;
  assign rd        = psel && penable && !pwrite;
  assign wr_ctrl   = wr && (paddr == USS_CTRL_OFF);
  assign wr_stat   = wr && (paddr == USS_STAT_OFF);
  assign wr_data   = wr && (paddr == USS_DATA_OFF);
  assign strobe_wr = wr_ctrl && pwdata[CTRL_STROBE_BIT];
  assign toggle_wr = wr_ctrl && pwdata[CTRL_TOGGLE_BIT];

  // Both pin groups synchronised before the position mux
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      pin_s1_q <= 6'h3F;
      pin_s2_q <= 6'h3F;
    end
    else
    begin
      pin_s1_q <= {pa_in, pb_in};
      pin_s2_q <= pin_s1_q;
    end
  end
  assign sdi_in  = pinpos_q ? pin_s2_q[3] : pin_s2_q[0];
  assign sclk_in = pinpos_q ? pin_s2_q[5] : pin_s2_q[2];

  // Edge detect on clock pin and timer event
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      sclk_prev_q <= 1'b1;
      sdi_prev_q  <= 1'b1;
      tm_s1_q     <= 1'b0;
      tm_s2_q     <= 1'b0;
      tm_prev_q   <= 1'b0;
    end
    else
    begin
      sclk_prev_q <= sclk_in;
      sdi_prev_q  <= sdi_in;
      tm_s1_q     <= timer_match;
      tm_s2_q     <= tm_s1_q;
      tm_prev_q   <= tm_s2_q;
    end
  end
  assign rise     = sclk_in && !sclk_prev_q;
  assign fall     = !sclk_in && sclk_prev_q;
  assign tm_pulse = tm_s2_q && !tm_prev_q;

  // Clock source selection
  always_comb
  begin
    shift_en = 1'b0;
    count_en = 1'b0;
    unique case (cs)
      CS_SOFT:
      begin
        shift_en = strobe_wr;
        count_en = strobe_wr;
      end
      CS_TIMER:
      begin
        shift_en = tm_pulse;
        count_en = tm_pulse;
      end
      CS_EXTP:
      begin
        shift_en = rise;
        count_en = strobe_sel ? toggle_wr : (rise || fall);
      end
      CS_EXTN:
      begin
        shift_en = fall;
        count_en = strobe_sel ? toggle_wr : (rise || fall);
      end
    endcase
  end

  // Control register; toggle not stored, strobe kept as counter source select
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      ctrl_q <= CTRL_RESET;
    else if (wr_ctrl)
      ctrl_q <= {pwdata[7:1], 1'b0};
  end

  // Pin position register
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pinpos_q <= PINPOS_RESET[0];
    else if (wr && paddr == USS_PINPOS_OFF)
      pinpos_q <= pwdata[0];
  end

  // Port output and direction bits
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      port_q <= PORT_RESET;
    else if (wr && paddr == USS_PORT_OFF)
      port_q <= pwdata[5:0];
    else if (toggle_wr)
      port_q[PORT_SCL_OUT] <= !port_q[PORT_SCL_OUT];
  end

  // Data shift register; shifted bit is previous-cycle sample
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      data_q <= DATA_RESET[DATA_W-1:0];
    else if (wr_data)
      data_q <= pwdata[DATA_W-1:0];
    else if (shift_en)
      data_q <= {data_q[DATA_W-2:0], sdi_prev_q};
  end

  // Counter and overflow flag; status write wins over count and over set
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      cnt_q <= CNT_RESET;
      ovf_q <= 1'b0;
    end
    else
    begin
      if (wr_stat)
        cnt_q <= pwdata[STAT_CNT_LSB +: 4];
      else if (count_en)
        cnt_q <= cnt_q + 4'h1;
      if (count_en && !wr_stat && cnt_q == CNT_MAX)
        ovf_q <= 1'b1;
      else if (wr_stat && pwdata[STAT_OVF_BIT])
        ovf_q <= 1'b0;
    end
  end

  // Start flag; write one clears, set wins
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      start_q <= 1'b0;
    else if (two_wire && start_detect)
      start_q <= 1'b1;
    else if (wr_stat && pwdata[STAT_START_BIT])
      start_q <= 1'b0;
  end

  // Output latch: opposite edge for external clock
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      dout_q <= 1'b0;
    else if ((cs == CS_EXTP && fall) || (cs == CS_EXTN && rise))
      dout_q <= data_q[DATA_W-1];
  end
  assign dout_now = cs[1] ? dout_q : data_q[DATA_W-1];

  // Pin drive by wire mode
  assign scl_hold = (start_q && port_q[PORT_SCL_DIR]) || (wm == WM_TWO_H && ovf_q);
  assign sda_low  = !data_q[DATA_W-1] || !port_q[PORT_SDA_OUT];
  assign scl_low  = !port_q[PORT_SCL_OUT] || scl_hold;

  always_comb
  begin
    ifc_out  = 3'b000;
    ifc_oe_n = 3'b111;
    unique case (wm)
      WM_OFF, WM_THREE:
      begin
        // Data-in and clock behave as port pins
        ifc_out[0]  = port_q[PORT_SDA_OUT];
        ifc_oe_n[0] = !port_q[PORT_SDA_DIR];
        ifc_out[2]  = port_q[PORT_SCL_OUT];
        ifc_oe_n[2] = !port_q[PORT_SCL_DIR];
        ifc_out[1]  = (wm == WM_THREE) ? dout_now : port_q[PORT_DO_OUT];
        ifc_oe_n[1] = !port_q[PORT_DO_DIR];
      end
      WM_TWO, WM_TWO_H:
      begin
        ifc_oe_n[0] = !(port_q[PORT_SDA_DIR] && sda_low);
        ifc_oe_n[2] = !(port_q[PORT_SCL_DIR] && scl_low);
        ifc_out[1]  = port_q[PORT_DO_OUT];
        ifc_oe_n[1] = !port_q[PORT_DO_DIR];
      end
    endcase
  end

  // Route to selected port
  assign pb_out        = pinpos_q ? 3'b000 : ifc_out;
  assign pb_oe_n       = pinpos_q ? 3'b111 : ifc_oe_n;
  assign pa_out        = pinpos_q ? ifc_out : 3'b000;
  assign pa_oe_n       = pinpos_q ? ifc_oe_n : 3'b111;
  assign pb_pullup_off = (!pinpos_q && two_wire) ? 3'b101 : 3'b000;
  assign pa_pullup_off = (pinpos_q && two_wire) ? 3'b101 : 3'b000;

  // Read mux
  always_comb
  begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (rd)
    begin
      unique case (paddr)
        USS_CTRL_OFF:   prdata[7:0] = {ctrl_q[7:2], 2'b00};
        USS_STAT_OFF:   prdata[7:0] = {start_q, ovf_q, 2'b00, cnt_q};
        USS_PINPOS_OFF: prdata[7:0] = {7'b000_0000, pinpos_q};
        USS_DATA_OFF:   prdata[DATA_W-1:0] = data_q;
        USS_PORT_OFF:   prdata[5:0] = port_q;
        default:        pslverr = 1'b1;
      endcase
    end
  end

  // Checks
  a_strobe_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
    (rd && paddr == USS_CTRL_OFF) |-> prdata[1:0] == 2'b00) else $error("strobe bits read nonzero");
  a_pinpos_reserved: assert property (@(posedge clk) disable iff (!reset_n)
    (rd && paddr == USS_PINPOS_OFF) |-> prdata[7:1] == 7'b000_0000) else $error("reserved bits nonzero");
  a_soft_counts: assert property (@(posedge clk) disable iff (!reset_n)
    (cs == CS_SOFT && strobe_wr && !wr_stat) |=> cnt_q == $past(cnt_q) + 4'h1) else $error("strobe no count");
  a_no_strobe_idle: assert property (@(posedge clk) disable iff (!reset_n)
    (cs == CS_SOFT && !strobe_wr && !wr_stat) |=> cnt_q == $past(cnt_q)) else $error("count without clock");
  a_overflow_sets: assert property (@(posedge clk) disable iff (!reset_n)
    (count_en && !wr_stat && cnt_q == CNT_MAX) |=> ovf_q && cnt_q == 4'h0) else $error("overflow missed");
  a_toggle_inverts: assert property (@(posedge clk) disable iff (!reset_n)
    (toggle_wr && !(wr && paddr == USS_PORT_OFF)) |=> port_q[PORT_SCL_OUT] != $past(port_q[PORT_SCL_OUT]))
    else $error("toggle failed");
  a_start_holds_scl: assert property (@(posedge clk) disable iff (!reset_n)
    (two_wire && start_q && port_q[PORT_SCL_DIR]) |-> ifc_oe_n[2] == 1'b0) else $error("start hold lost");
  a_start_clear_one: assert property (@(posedge clk) disable iff (!reset_n)
    (start_q && !(wr_stat && pwdata[STAT_START_BIT])) |=> start_q) else $error("start flag lost");
  a_sda_release: assert property (@(posedge clk) disable iff (!reset_n)
    (two_wire && data_q[DATA_W-1] && port_q[PORT_SDA_OUT]) |-> ifc_oe_n[0]) else $error("sda driven");
  a_hold_overflow: assert property (@(posedge clk) disable iff (!reset_n)
    (wm == WM_TWO_H && ovf_q && port_q[PORT_SCL_DIR]) |-> !ifc_oe_n[2]) else $error("ovf hold lost");

  // Counter clock events, one cycle each
  sequence s_ext_edge;
    cs[1] && !strobe_sel && (rise || fall) && !wr_stat;
  endsequence
  sequence s_toggle_count;
    cs[1] && strobe_sel && toggle_wr;
  endsequence
  sequence s_timer_event;
    cs == CS_TIMER && tm_pulse && !wr_stat;
  endsequence

  a_ext_both_edges: assert property (@(posedge clk) disable iff (!reset_n)
    s_ext_edge |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("external edge not counted");
  a_toggle_counts: assert property (@(posedge clk) disable iff (!reset_n)
    s_toggle_count |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("toggle strobe not counted");
  a_timer_counts: assert property (@(posedge clk) disable iff (!reset_n)
    s_timer_event |=> cnt_q == $past(cnt_q) + 4'h1)
    else $error("timer event not counted");
  a_timer_ignores_strobe: assert property (@(posedge clk) disable iff (!reset_n)
    (cs == CS_TIMER && strobe_wr && !tm_pulse) |=> data_q == $past(data_q))
    else $error("strobe shifted in timer mode");
  a_latch_holds: assert property (@(posedge clk) disable iff (!reset_n)
    ((cs == CS_EXTN && !rise) || (cs == CS_EXTP && !fall)) |=> dout_q == $past(dout_q))
    else $error("output latch moved on sampling edge");
  a_pullups_off: assert property (@(posedge clk) disable iff (!reset_n)
    two_wire |-> (pinpos_q ? pa_pullup_off : pb_pullup_off) == 3'b101)
    else $error("pull-ups left on in two-wire mode");
  a_three_wire_ports: assert property (@(posedge clk) disable iff (!reset_n)
    (wm == WM_THREE) |-> ifc_oe_n[2] == !port_q[PORT_SCL_DIR] && ifc_out[0] == port_q[PORT_SDA_OUT])
    else $error("three-wire port pins altered");
  a_route_released: assert property (@(posedge clk) disable iff (!reset_n)
    (pinpos_q ? pb_oe_n : pa_oe_n) == 3'b111)
    else $error("unselected port driven");
  a_mode_keeps_data: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_ctrl && !shift_en) |=> data_q == $past(data_q))
    else $error("control write disturbed data");
  a_mode_keeps_count: assert property (@(posedge clk) disable iff (!reset_n)
    (wr_ctrl && !count_en) |=> cnt_q == $past(cnt_q))
    else $error("control write disturbed count");

endmodule
`default_nettype wire

// ### verif/uss_peer.sv
// Far-side serial party: bus pull-ups and a link clock on the clock pin
`default_nettype none
module uss_peer (
  // Frame control
  input  wire logic       run,
  // Device pin drive
  input  wire logic [2:0] pb_out,
  input  wire logic [2:0] pb_oe_n,
  input  wire logic [2:0] pa_out,
  input  wire logic [2:0] pa_oe_n,
  // Resolved pin levels
  output logic [2:0]      pb_in,
  output logic [2:0]      pa_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic sclk;
  // Link clock stands high between frames
  initial
  begin
    sclk = 1'b1;
    forever
    begin
      #32;
      sclk = run ? ~sclk : 1'b1;
    end
  end
  // Released lines go to the pull-up level, except the clock pin, which follows the link clock
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pb_in[i] = pb_oe_n[i] ? ((i == 2) ? sclk : 1'b1) : pb_out[i];
      pa_in[i] = pa_oe_n[i] ? ((i == 2) ? sclk : 1'b1) : pa_out[i];
    end
  end
endmodule
`default_nettype wire

// ### verif/universal_serial_shift_control_bench.sv
// Self-checking bench for the serial shift control block
`default_nettype none
module universal_serial_shift_control_bench;
  import uss_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic        timer_match, start_detect, run, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0]  pb_in, pb_out, pb_oe_n, pb_pullup_off, pa_in, pa_out, pa_oe_n, pa_pullup_off;
  int          err_total, cmp_count, cyc;

  uss_core i_uss_core (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .timer_match(timer_match), .start_detect(start_detect), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe_n(pb_oe_n), .pb_pullup_off(pb_pullup_off), .pa_in(pa_in), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pa_pullup_off(pa_pullup_off));
  uss_peer i_uss_peer (.run(run), .pb_out(pb_out), .pb_oe_n(pb_oe_n), .pa_out(pa_out),
    .pa_oe_n(pa_oe_n), .pb_in(pb_in), .pa_in(pa_in));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Setup cycle, then access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rdata = prdata;
    rerr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdata, {24'h0, exp});
  endtask

  task automatic t_reset();
    rdc(USS_CTRL_OFF, 8'h00);
    rdc(USS_STAT_OFF, 8'h00);
    rdc(USS_DATA_OFF, 8'h00);
    rdc(USS_PORT_OFF, 8'h00);
    chk(pb_oe_n, 3'b111);
    apb(1'b0, 12'h014, 32'h0);
    chk(rerr, 1'b1);
    wr(USS_PINPOS_OFF, 8'hFF);
    rdc(USS_PINPOS_OFF, 8'h01);
    wr(USS_PINPOS_OFF, 8'h00);
  endtask

  task automatic t_toggle();
    wr(USS_CTRL_OFF, 8'h01);
    rdc(USS_PORT_OFF, 8'h04);
    chk(pb_oe_n[2], 1'b1);
    rdc(USS_CTRL_OFF, 8'h00);
    wr(USS_PORT_OFF, 8'h20);
    wr(USS_CTRL_OFF, 8'h11);
    idle(2);
    chk({pb_oe_n[2], pb_out[2]}, 2'b01);
    wr(USS_CTRL_OFF, 8'h00);
    wr(USS_PORT_OFF, 8'h00);
  endtask

  task automatic t_soft();
    wr(USS_DATA_OFF, 8'h80);
    wr(USS_PORT_OFF, 8'h10);
    wr(USS_CTRL_OFF, 8'h10);
    wr(USS_STAT_OFF, 8'h0F);
    idle(2);
    chk({pb_oe_n[1], pb_out[1]}, 2'b01);
    wr(USS_CTRL_OFF, 8'h12);
    idle(1);
    chk({pb_oe_n[1], pb_out[1]}, 2'b00);
    rdc(USS_DATA_OFF, 8'h01);
    rdc(USS_STAT_OFF, 8'h40);
    rdc(USS_CTRL_OFF, 8'h10);
    wr(USS_CTRL_OFF, 8'h10);
    rdc(USS_DATA_OFF, 8'h01);
    wr(USS_STAT_OFF, 8'h40);
    wr(USS_PORT_OFF, 8'h00);
  endtask

  task automatic t_timer();
    wr(USS_CTRL_OFF, 8'h04);
    repeat (3)
    begin
      timer_match <= 1'b1;
      idle(2);
      timer_match <= 1'b0;
      idle(6);
    end
    wr(USS_CTRL_OFF, 8'h06);
    idle(2);
    rdc(USS_STAT_OFF, 8'h03);
    wr(USS_STAT_OFF, 8'h00);
  endtask

  task automatic t_ext();
    wr(USS_CTRL_OFF, 8'h08);
    idle(2);
    #2 run = 1'b1;
    #128 run = 1'b0;
    idle(10);
    rdc(USS_STAT_OFF, 8'h04);
    wr(USS_CTRL_OFF, 8'h0A);
    wr(USS_CTRL_OFF, 8'h0B);
    wr(USS_CTRL_OFF, 8'h0B);
    rdc(USS_STAT_OFF, 8'h06);
    rdc(USS_PORT_OFF, 8'h00);
    wr(USS_CTRL_OFF, 8'h00);
    wr(USS_STAT_OFF, 8'h00);
  endtask

  task automatic t_two();
    wr(USS_DATA_OFF, 8'h80);
    wr(USS_PORT_OFF, 8'h2D);
    wr(USS_CTRL_OFF, 8'h20);
    idle(2);
    chk({pb_pullup_off, pb_oe_n}, 6'b101_111);
    wr(USS_DATA_OFF, 8'h00);
    idle(2);
    chk({pb_oe_n[0], pb_out[0]}, 2'b00);
    wr(USS_PORT_OFF, 8'h29);
    idle(2);
    chk(pb_oe_n[2], 1'b0);
    wr(USS_PORT_OFF, 8'h2D);
    start_detect <= 1'b1;
    idle(1);
    start_detect <= 1'b0;
    idle(2);
    chk(pb_oe_n[2], 1'b0);
    rdc(USS_STAT_OFF, 8'h80);
    wr(USS_STAT_OFF, 8'h00);
    idle(2);
    chk(pb_oe_n[2], 1'b0);
    wr(USS_STAT_OFF, 8'h80);
    idle(2);
    chk(pb_oe_n[2], 1'b1);
    wr(USS_STAT_OFF, 8'h0F);
    wr(USS_CTRL_OFF, 8'h32);
    idle(2);
    chk(pb_oe_n[2], 1'b0);
    wr(USS_STAT_OFF, 8'h40);
    idle(2);
    chk(pb_oe_n[2], 1'b1);
    wr(USS_PINPOS_OFF, 8'h01);
    idle(2);
    chk({pa_pullup_off, pa_oe_n}, 6'b101_110);
    wr(USS_PINPOS_OFF, 8'h00);
  endtask

  task automatic t_extn();
    wr(USS_PINPOS_OFF, 8'h01);
    wr(USS_PORT_OFF, 8'h10);
    wr(USS_DATA_OFF, 8'h20);
    wr(USS_STAT_OFF, 8'h00);
    wr(USS_CTRL_OFF, 8'h1C);
    idle(2);
    #2 run = 1'b1;
    #128 run = 1'b0;
    idle(10);
    rdc(USS_DATA_OFF, 8'h83);
    rdc(USS_STAT_OFF, 8'h04);
    wr(USS_DATA_OFF, 8'h00);
    idle(1);
    chk({pa_oe_n[1], pa_out[1], pb_oe_n[1]}, 3'b011);
    wr(USS_CTRL_OFF, 8'h00);
    wr(USS_PORT_OFF, 8'h00);
    wr(USS_PINPOS_OFF, 8'h00);
  endtask

  task automatic t_midrst();
    wr(USS_PORT_OFF, 8'h3F);
    wr(USS_DATA_OFF, 8'hA5);
    wr(USS_PINPOS_OFF, 8'h01);
    wr(USS_CTRL_OFF, 8'h3C);
    reset_n <= 1'b0;
    idle(10);
    reset_n <= 1'b1;
    chk({pb_oe_n, pa_oe_n, pb_pullup_off, pa_pullup_off}, 12'hFC0);
    rdc(USS_CTRL_OFF, 8'h00);
    rdc(USS_PORT_OFF, 8'h00);
    rdc(USS_DATA_OFF, 8'h00);
    rdc(USS_PINPOS_OFF, 8'h00);
  endtask

  initial
  begin
    reset_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    timer_match = 1'b0;
    start_detect = 1'b0;
    run = 1'b0;
    idle(10);
    reset_n <= 1'b1;
    t_reset();
    t_toggle();
    t_soft();
    t_timer();
    t_ext();
    t_two();
    t_extn();
    t_midrst();
    finish_test();
  end
endmodule
`default_nettype wire
